// *** src/pattern_regs_pkg.sv ***
// constants shared by the indirect access port and the pattern page register bank
package pattern_regs_pkg;

  // main register space locations
  localparam logic [7:0] MAIN_IND_SELECT_ADDR = 8'hb0;
  localparam logic [7:0] MAIN_IND_OFFSET_ADDR = 8'hb1;
  localparam logic [7:0] MAIN_IND_VALUE_ADDR = 8'hb2;
  localparam logic [7:0] MAIN_TOP_RSVD_FIRST = 8'hfc;

  // indirect block select register layout
  localparam int SEL_AUTOINC_BIT = 0;
  localparam int SEL_BLOCK_LSB = 2;
  localparam int SEL_BLOCK_MSB = 4;
  localparam logic [7:0] SEL_WRITE_MASK = 8'h1d;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] OFFSET_RESET = 8'h00;
  localparam logic [7:0] OFFSET_STEP = 8'h01;

  // register sets that sit behind the indirect port
  typedef enum logic [2:0] {
    BLK_PATTERN = 3'b000,
    BLK_CSI_TIMING = 3'b001,
    BLK_ANALOG = 3'b010
  } block_sel_t;

  // pattern page offsets
  localparam logic [7:0] PG_RSVD = 8'h00;
  localparam logic [7:0] PG_CONTROL = 8'h01;
  localparam logic [7:0] PG_CONFIG = 8'h02;
  localparam logic [7:0] PG_IDENT = 8'h03;
  localparam logic [7:0] PG_LINE_HI = 8'h04;
  localparam logic [7:0] PG_LINE_LO = 8'h05;
  localparam logic [7:0] PG_BAR_HI = 8'h06;
  localparam logic [7:0] PG_BAR_LO = 8'h07;
  localparam logic [7:0] PG_ACT_HI = 8'h08;
  localparam logic [7:0] PG_ACT_LO = 8'h09;
  localparam int PG_WIDE_BYTES = 6;

  // pattern page field positions
  localparam int CTL_ON_BIT = 0;
  localparam int CFG_FIXED_BIT = 7;
  localparam int CFG_BARS_MSB = 5;
  localparam int CFG_BARS_LSB = 4;
  localparam int CFG_BLOCK_MSB = 3;
  localparam int CFG_BLOCK_LSB = 0;
  localparam int IDENT_VC_MSB = 7;
  localparam int IDENT_VC_LSB = 6;
  localparam int IDENT_DT_MSB = 5;
  localparam int IDENT_DT_LSB = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hbf;
  localparam logic [3:0] BLOCK_SIZE_ILLEGAL = 4'h0;

  // pattern page reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h33;
  localparam logic [7:0] IDENT_RESET = 8'h24;
  localparam logic [15:0] LINE_BYTES_RESET = 16'h0780;
  localparam logic [15:0] BAR_BYTES_RESET = 16'h00f0;
  localparam logic [15:0] ACT_LINES_RESET = 16'h01e0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

endpackage : pattern_regs_pkg

// *** src/indirect_access_port.sv ***
// indirect access port: block select, offset and value registers in the main space
`timescale 1ns/1ps
module indirect_access_port
  import pattern_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] page_rdata_i,
  output logic [7:0] reg_rdata_o,
  output logic page_wr_o,
  output logic [7:0] page_addr_o,
  output logic [7:0] page_wdata_o
);

  logic [7:0] select_q;
  logic [7:0] select_d;
  logic [7:0] offset_q;
  logic [7:0] offset_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // main space decode; a write in the same cycle as a read wins and the read is dropped
  wire read_take = reg_rd_i & ~reg_wr_i;
  wire hit_select = (reg_addr_i == MAIN_IND_SELECT_ADDR);
  wire hit_offset = (reg_addr_i == MAIN_IND_OFFSET_ADDR);
  wire hit_value = (reg_addr_i == MAIN_IND_VALUE_ADDR);
  wire auto_inc = select_q[SEL_AUTOINC_BIT];
  wire pattern_sel = (block_sel_t'(select_q[SEL_BLOCK_MSB:SEL_BLOCK_LSB]) == BLK_PATTERN);
  wire value_access = hit_value & (reg_wr_i | read_take);

  // only the pattern set lives here; other sets read as zero and swallow writes
  assign page_wr_o = reg_wr_i & hit_value & pattern_sel;
  assign page_addr_o = offset_q;
  assign page_wdata_o = reg_wdata_i;

  // offset advances after every value access when auto-increment is on
  assign select_d = (reg_wr_i & hit_select) ? (reg_wdata_i & SEL_WRITE_MASK) : select_q;
  assign offset_d = (reg_wr_i & hit_offset) ? reg_wdata_i :
                    (value_access & auto_inc) ? offset_q + OFFSET_STEP : offset_q;

  // read data is captured at the read strobe, before the offset moves
  assign rdata_d = ~read_take ? rdata_q :
                   hit_select ? select_q :
                   hit_offset ? offset_q :
                   (hit_value & pattern_sel) ? page_rdata_i : ZERO_BYTE;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      select_q <= SEL_RESET;
      offset_q <= OFFSET_RESET;
      rdata_q <= ZERO_BYTE;
    end else begin
      select_q <= select_d;
      offset_q <= offset_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule : indirect_access_port

// *** src/indirect_pattern_gen_regs.sv ***
// pattern generator configuration page reached through the indirect access port
//
// Summary of operation
// - Block select, offset and value registers sit at main addresses 0xb0 to 0xb2.
// - Block select picks pattern, CSI-2 timing or analog register set.
// - Host reads by selecting block, setting offset, reading value; device returns contents.
// - With auto-increment on, offset advances by one after each value access.
// - Main addresses 0xfc to 0xff read as zero.
// - Pattern page offset zero reads as zero.
// - Offset one bit 0 turns generator on; resets off.
// - Config bit 7 picks colour bars (0) or fixed colour (1); resets to bars.
// - Four-bit block size sets fixed field bytes, 1 to 15, reset three.
// - Two-bit virtual channel goes into each packet; resets zero.
// - Six-bit data type goes into each packet; resets to 24-bit RGB code.
// - Line size, high byte offset 4, low offset 5, default 1920 bytes.
// - Bar size, high byte offset 6, low offset 7, sets all but last bar.
// - Last bar fills what the line leaves after the earlier bars.
// - Offset 8 holds active lines high byte, reset one, 480 lines default.
// - Active lines low byte sits at offset 9, joined with offset 8.
`timescale 1ns/1ps
module indirect_pattern_gen_regs
  import pattern_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic frame_start_i,
  output logic [7:0] reg_rdata_o,
  output logic pattern_on_o,
  output logic fixed_colour_select_o,
  output logic [3:0] bar_count_o,
  output logic [3:0] block_bytes_o,
  output logic [1:0] packet_virtual_channel_o,
  output logic [5:0] packet_data_type_o,
  output logic [15:0] active_line_bytes_o,
  output logic [15:0] colour_bar_bytes_o,
  output logic [15:0] last_bar_bytes_o,
  output logic [15:0] active_lines_count_o
);

  logic page_wr;
  logic [7:0] page_addr;
  logic [7:0] page_wdata;
  logic [7:0] page_rdata;

  // main space handling and the offset/auto-increment machinery
  indirect_access_port indirect_access_port_i (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .page_rdata_i(page_rdata),
    .reg_rdata_o(reg_rdata_o),
    .page_wr_o(page_wr),
    .page_addr_o(page_addr),
    .page_wdata_o(page_wdata)
  );

  logic [7:0] control_q;
  logic [7:0] control_d;
  logic [7:0] config_q;
  logic [7:0] config_d;
  logic [7:0] ident_q;
  logic [7:0] ident_d;

  // page write decode for the single-byte registers
  wire wr_control = page_wr & (page_addr == PG_CONTROL);
  wire wr_config = page_wr & (page_addr == PG_CONFIG);
  wire wr_ident = page_wr & (page_addr == PG_IDENT);

  // reserved control bits never store, so they read back as zero
  assign control_d = wr_control ? {7'h00, page_wdata[CTL_ON_BIT]} : control_q;

  // a block size of zero is illegal; such a write keeps the old size and updates the rest
  wire [3:0] new_block = page_wdata[CFG_BLOCK_MSB:CFG_BLOCK_LSB];
  wire [3:0] kept_block = (new_block == BLOCK_SIZE_ILLEGAL) ? config_q[CFG_BLOCK_MSB:CFG_BLOCK_LSB] : new_block;
  assign config_d = wr_config ? ((page_wdata & CFG_WRITE_MASK) & 8'hf0) | {4'h0, kept_block} : config_q;
  assign ident_d = wr_ident ? page_wdata : ident_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      control_q <= CTL_RESET;
      config_q <= CFG_RESET;
      ident_q <= IDENT_RESET;
    end else begin
      control_q <= control_d;
      config_q <= config_d;
      ident_q <= ident_d;
    end
  end

  // the six bytes of the sixteen-bit fields, offsets 4 to 9, high byte first
  localparam logic [7:0] WIDE_RESET [PG_WIDE_BYTES] = '{
    LINE_BYTES_RESET[15:8], LINE_BYTES_RESET[7:0],
    BAR_BYTES_RESET[15:8], BAR_BYTES_RESET[7:0],
    ACT_LINES_RESET[15:8], ACT_LINES_RESET[7:0]
  };
  logic [7:0] wide_q [PG_WIDE_BYTES];

  genvar gi;
  generate
    for (gi = 0; gi < PG_WIDE_BYTES; gi++) begin : g_wide
      localparam logic [7:0] BYTE_OFFSET = PG_LINE_HI + 8'(gi);
      wire wr_byte = page_wr & (page_addr == BYTE_OFFSET);
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          wide_q[gi] <= WIDE_RESET[gi];
        end else if (wr_byte) begin
          wide_q[gi] <= page_wdata;
        end
      end
    end
  endgenerate

  // programmed sixteen-bit values as software sees them
  wire [15:0] line_prog = {wide_q[0], wide_q[1]};
  wire [15:0] bar_prog = {wide_q[2], wide_q[3]};
  wire [15:0] act_prog = {wide_q[4], wide_q[5]};

  // page read selection; unlisted offsets and offset zero answer zero
  wire hit_wide = (page_addr >= PG_LINE_HI) & (page_addr <= PG_ACT_LO);
  wire [2:0] wide_idx = 3'(page_addr - PG_LINE_HI);
  assign page_rdata = (page_addr == PG_RSVD) ? ZERO_BYTE :
                      (page_addr == PG_CONTROL) ? control_q :
                      (page_addr == PG_CONFIG) ? config_q :
                      (page_addr == PG_IDENT) ? ident_q :
                      hit_wide ? wide_q[wide_idx] : ZERO_BYTE;

  // width of all bars but the last: bar size times (count - 1), via shift and subtract
  wire [1:0] bars_code = config_q[CFG_BARS_MSB:CFG_BARS_LSB];
  wire [18:0] bar_wide = {3'b000, bar_prog};
  wire [18:0] leading_bytes = 19'((bar_wide << bars_code) - bar_wide);
  wire [18:0] line_wide = {3'b000, line_prog};
  // a bar size too large for the line leaves no room, so the last bar is clamped to zero
  wire [15:0] last_bar = (line_wide > leading_bytes) ? 16'(line_wide - leading_bytes) : 16'h0000;

  // sixteen-bit fields are copied whole while the generator is off or at a frame start,
  // so while the generator runs, a pair reaches the video path only at a frame start
  wire take_shadow = ~control_q[CTL_ON_BIT] | frame_start_i;

  logic [15:0] line_sh_q;
  logic [15:0] bar_sh_q;
  logic [15:0] last_sh_q;
  logic [15:0] act_sh_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      line_sh_q <= LINE_BYTES_RESET;
      bar_sh_q <= BAR_BYTES_RESET;
      last_sh_q <= 16'h0000;
      act_sh_q <= ACT_LINES_RESET;
    end else if (take_shadow) begin
      line_sh_q <= line_prog;
      bar_sh_q <= bar_prog;
      last_sh_q <= last_bar;
      act_sh_q <= act_prog;
    end
  end

  // outputs toward the pattern datapath
  assign pattern_on_o = control_q[CTL_ON_BIT];
  assign fixed_colour_select_o = config_q[CFG_FIXED_BIT];
  assign bar_count_o = 4'h1 << bars_code;
  assign block_bytes_o = config_q[CFG_BLOCK_MSB:CFG_BLOCK_LSB];
  assign packet_virtual_channel_o = ident_q[IDENT_VC_MSB:IDENT_VC_LSB];
  assign packet_data_type_o = ident_q[IDENT_DT_MSB:IDENT_DT_LSB];
  assign active_line_bytes_o = line_sh_q;
  assign colour_bar_bytes_o = bar_sh_q;
  assign last_bar_bytes_o = last_sh_q;
  assign active_lines_count_o = act_sh_q;

endmodule : indirect_pattern_gen_regs

// *** dv/indirect_pattern_gen_regs_asserts.sv ***
// assertion checker for the pattern page register bank
`timescale 1ns/1ps
module indirect_pattern_gen_regs_asserts
  import pattern_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic frame_start_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic pattern_on_o,
  input wire logic fixed_colour_select_o,
  input wire logic [3:0] bar_count_o,
  input wire logic [3:0] block_bytes_o,
  input wire logic [1:0] packet_virtual_channel_o,
  input wire logic [5:0] packet_data_type_o,
  input wire logic [15:0] active_line_bytes_o,
  input wire logic [15:0] colour_bar_bytes_o,
  input wire logic [15:0] last_bar_bytes_o,
  input wire logic [15:0] active_lines_count_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // bytes taken by all bars but the last; wide so an overflow clamps instead of wrapping
  logic [19:0] prod;
  assign prod = colour_bar_bytes_o * (bar_count_o - 4'h1);
  // reset checks must run while reset is high, so they switch the default disable off
  a_reset_fields:
    assert property (disable iff (1'b0) srst_i |=> !pattern_on_o && !fixed_colour_select_o
      && bar_count_o == 4'h8 && block_bytes_o == 4'h3 && reg_rdata_o == ZERO_BYTE) else $error("reset fields wrong");
  a_reset_ident:
    assert property (disable iff (1'b0) srst_i |=> packet_virtual_channel_o == 2'h0
      && packet_data_type_o == 6'h24) else $error("reset packet ident wrong");
  a_reset_sizes:
    assert property (disable iff (1'b0) srst_i |=> active_line_bytes_o == LINE_BYTES_RESET
      && active_lines_count_o == ACT_LINES_RESET) else $error("reset sizes wrong");
  a_bar_decode:
    assert property ($onehot(bar_count_o) && bar_count_o <= 4'h8) else $error("bar count not 1 2 4 8");
  a_block_legal:
    assert property (block_bytes_o != BLOCK_SIZE_ILLEGAL) else $error("block size zero");
  a_last_bar_fill:
    assert property (!$past(srst_i) && !$past(pattern_on_o) && $stable(bar_count_o) |->
      last_bar_bytes_o == ((prod > {4'h0, active_line_bytes_o}) ? 16'h0000 : active_line_bytes_o - prod[15:0]))
      else $error("last bar length wrong");
  a_shadow_frozen:
    assert property (!$past(srst_i) && $past(pattern_on_o) && !$past(frame_start_i) |-> $stable(active_line_bytes_o)
      && $stable(colour_bar_bytes_o) && $stable(active_lines_count_o)) else $error("shadow moved while on");
  a_rdata_hold:
    assert property (!$past(srst_i) && (!$past(reg_rd_i) || $past(reg_wr_i)) |-> $stable(reg_rdata_o))
      else $error("read data moved without read");
  a_top_zero:
    assert property (reg_rd_i && !reg_wr_i && reg_addr_i >= MAIN_TOP_RSVD_FIRST |=> reg_rdata_o == ZERO_BYTE)
      else $error("top reserved read not zero");
  a_unmapped_zero:
    assert property (reg_rd_i && !reg_wr_i && reg_addr_i < MAIN_IND_SELECT_ADDR |=> reg_rdata_o == ZERO_BYTE)
      else $error("unmapped read not zero");
  // main scenarios reached
  c_value_read: cover property (reg_rd_i && reg_addr_i == MAIN_IND_VALUE_ADDR);
  c_frame_load: cover property (pattern_on_o && frame_start_i);
  c_top_read: cover property (reg_rd_i && reg_addr_i >= MAIN_TOP_RSVD_FIRST);
endmodule : indirect_pattern_gen_regs_asserts

bind indirect_pattern_gen_regs indirect_pattern_gen_regs_asserts indirect_pattern_gen_regs_asserts_i (.*);

// *** dv/tb_top.sv ***
// self-checking bench for the pattern page register bank
`timescale 1ns/1ps
module tb_top
  import pattern_regs_pkg::*;
;
  logic clk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, frame_start_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic pattern_on_o, fixed_colour_select_o;
  logic [3:0] bar_count_o, block_bytes_o;
  logic [1:0] packet_virtual_channel_o;
  logic [5:0] packet_data_type_o;
  logic [15:0] active_line_bytes_o, colour_bar_bytes_o, last_bar_bytes_o, active_lines_count_o;
  int failures = 0, n_tests = 0;
  indirect_pattern_gen_regs indirect_pattern_gen_regs_i (.*);
  // 50 ns period
  always #25 clk_i = ~clk_i;
  // arguments are copied at the call, so callers step past the launching edge before calling
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle strobe, then a low cycle so calls never collide on one edge;
  // the closing wait lets the register updates land before any check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask : rdchk
  // called in the cycle reset drops; the first edge after release loads the shadows
  task automatic t_defaults;
    @(posedge clk_i);
    #1;
    chk({pattern_on_o, fixed_colour_select_o, bar_count_o, block_bytes_o}, 10'h083);
    chk(colour_bar_bytes_o, 16'd240);
    chk({packet_virtual_channel_o, packet_data_type_o}, 8'h24);
    chk(active_line_bytes_o, 16'd1920);
    chk(last_bar_bytes_o, 16'd240);
    chk(active_lines_count_o, 16'd480);
  endtask : t_defaults
  task automatic t_read_page;
    logic [7:0] exp [10] = '{8'h00, 8'h00, 8'h33, 8'h24, 8'h07, 8'h80, 8'h00, 8'hf0, 8'h01, 8'he0};
    wr(MAIN_IND_SELECT_ADDR, 8'h01);
    wr(MAIN_IND_OFFSET_ADDR, PG_RSVD);
    for (int i = 0; i < 10; i++) begin
      rdchk(MAIN_IND_VALUE_ADDR, exp[i]);
    end
  endtask : t_read_page
  task automatic t_write_page;
    logic [7:0] dat [8] = '{8'hd2, 8'h45, 8'h01, 8'h00, 8'h00, 8'h40, 8'h00, 8'h02};
    wr(MAIN_IND_OFFSET_ADDR, PG_CONFIG);
    for (int i = 0; i < 8; i++) begin
      wr(MAIN_IND_VALUE_ADDR, dat[i]);
    end
    wr(MAIN_IND_OFFSET_ADDR, PG_CONFIG);
    rdchk(MAIN_IND_VALUE_ADDR, 8'h92);
    chk({fixed_colour_select_o, bar_count_o, block_bytes_o}, 9'h122);
    chk({packet_virtual_channel_o, packet_data_type_o}, 8'h45);
    chk(active_line_bytes_o, 16'h0100);
    chk(colour_bar_bytes_o, 16'h0040);
    chk(last_bar_bytes_o, 16'h00c0);
    chk(active_lines_count_o, 16'h0002);
    // block size zero rides along: it must leave the old size in place
    for (int c = 0; c < 4; c++) begin
      wr(MAIN_IND_OFFSET_ADDR, PG_CONFIG);
      wr(MAIN_IND_VALUE_ADDR, {4'h0 | c[1:0], 4'h0});
      chk(bar_count_o, 4'h1 << c);
    end
    chk(block_bytes_o, 4'h2);
  endtask : t_write_page
  task automatic t_reserved;
    wr(MAIN_TOP_RSVD_FIRST, 8'hff);
    rdchk(MAIN_TOP_RSVD_FIRST, 8'h00);
    rdchk(8'hff, 8'h00);
    rdchk(8'h10, 8'h00);
    wr(MAIN_IND_OFFSET_ADDR, 8'h0a);
    rdchk(MAIN_IND_VALUE_ADDR, 8'h00);
    wr(MAIN_IND_SELECT_ADDR, 8'hff);
    rdchk(MAIN_IND_SELECT_ADDR, 8'h1d);
    wr(MAIN_IND_SELECT_ADDR, 8'h09);
    wr(MAIN_IND_OFFSET_ADDR, PG_IDENT);
    wr(MAIN_IND_VALUE_ADDR, 8'h3f);
    rdchk(MAIN_IND_VALUE_ADDR, 8'h00);
    wr(MAIN_IND_SELECT_ADDR, 8'h00);
    wr(MAIN_IND_OFFSET_ADDR, PG_IDENT);
    rdchk(MAIN_IND_VALUE_ADDR, 8'h45);
    rdchk(MAIN_IND_VALUE_ADDR, 8'h45);
  endtask : t_reserved
  task automatic t_shadow;
    wr(MAIN_IND_SELECT_ADDR, 8'h01);
    wr(MAIN_IND_OFFSET_ADDR, PG_CONTROL);
    wr(MAIN_IND_VALUE_ADDR, 8'hff);
    chk(pattern_on_o, 1'b1);
    wr(MAIN_IND_OFFSET_ADDR, PG_LINE_LO);
    wr(MAIN_IND_VALUE_ADDR, 8'h80);
    repeat (2) @(posedge clk_i);
    #1;
    chk(active_line_bytes_o, 16'h0100);
    @(posedge clk_i);
    frame_start_i <= 1'b1;
    @(posedge clk_i);
    frame_start_i <= 1'b0;
    #1;
    chk(active_line_bytes_o, 16'h0180);
    chk(last_bar_bytes_o, 16'h0000);
    wr(MAIN_IND_OFFSET_ADDR, PG_CONTROL);
    rdchk(MAIN_IND_VALUE_ADDR, 8'h01);
  endtask : t_shadow
  // reset in mid-run must bring every field back, not just the power-up state
  task automatic t_reset;
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    t_defaults();
    rdchk(MAIN_IND_SELECT_ADDR, 8'h00);
  endtask : t_reset
  task automatic test_done;
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // main sequence; the first shadow load lands one edge after release
  initial begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    t_defaults();
    t_read_page();
    t_write_page();
    t_reserved();
    t_shadow();
    t_reset();
    test_done();
  end
  // watchdog well past the roughly 120 cycles the tests need
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule : tb_top
